/* File: hw/ccrb_defs.vh */
// Constants for the charger control register bank.
// Assumes an 8-bit register map reached over an I2C target at one address.
`ifndef CCRB_DEFS_VH
`define CCRB_DEFS_VH
// ==========================================================
// Bus address and register offsets
`define CCRB_I2C_ADDR 7'h03
`define CCRB_OFS_R0 8'h00
`define CCRB_OFS_R1 8'h01
`define CCRB_OFS_R2 8'h02
`define CCRB_OFS_R3 8'h03
`define CCRB_OFS_R4 8'h04
`define CCRB_OFS_R5 8'h05
`define CCRB_OFS_R6 8'h06
`define CCRB_OFS_R7 8'h07
`define CCRB_OFS_R8 8'h08
`define CCRB_OFS_R9 8'h09
// ==========================================================
// Reset values
`define CCRB_RST_R0 8'h9f
`define CCRB_RST_R1 8'hac
`define CCRB_RST_R2 8'h0f
`define CCRB_RST_R3 8'h91
`define CCRB_RST_R4 8'ha3
`define CCRB_RST_R5 8'h7a
`define CCRB_RST_R6 8'hc0
`define CCRB_RST_R7 8'h37
// Bits reset by watchdog expiry as well as software reset
`define CCRB_WDM_R0 8'h00
`define CCRB_WDM_R1 8'hff
`define CCRB_WDM_R2 8'h7f
`define CCRB_WDM_R3 8'hff
`define CCRB_WDM_R4 8'hff
`define CCRB_WDM_R5 8'h1f
`define CCRB_WDM_R6 8'hdf
`define CCRB_WDM_R7 8'hf0
// ==========================================================
// Field positions
`define CCRB_BIT_SWRST 7
`define CCRB_BIT_KICK 6
`define CCRB_BIT_OFFTIME 5
`define CCRB_BIT_BYPASS_OFF 4
`define CCRB_BIT_CHG_DIS_N 3
`define CCRB_BIT_WD_DIS 7
`define CCRB_BIT_TERM_EN 4
`define CCRB_BIT_TMR_EN 3
`define CCRB_BIT_KEEP_CUR 0
`define CCRB_BIT_HALF_RATE 6
`define CCRB_BIT_SW_DIS 5
`define CCRB_ICC_MAX 6'h38
// ==========================================================
// Timing: seconds and cycles at 50 MHz
`define CCRB_CLK_HZ 50000000
`define CCRB_WD_UNIT_S 40
`define CCRB_SEC_CYC (`CCRB_CLK_HZ)
`define CCRB_OFF_SHORT_S 2
`define CCRB_OFF_LONG_S 4
`endif

/* File: hw/ccrb_top.v */
// Charger control register bank with I2C target, watchdog and recycle timer.
// Assumes analog loops read the decoded fields and drive status inputs.
`timescale 1ns/1ps
`include "ccrb_defs.vh"

// Behaviour
// RL1: Input current limit 4-bit, 50 mA plus 30 mA/step, reset all-ones.
// RL2: Button deglitch 8 s plus 4 s/step, default 16 s.
// RL3: After recycle, both switches off 2 s or 4 s by off-time bit.
// RL4: Bypass-off bit controls only the bypass switch; 0 keeps it on.
// RL5: Charge-disable bit 0 enables charging; reset value 1 disables.
// RL6: Undervoltage threshold 2.4 V plus 0.09 V/step, default code 100.
// RL7: Software reset restores marked fields; watchdog restores its subset.
// RL8: Host writes kick bit to restart watchdog; device restarts count.
// RL9: Fast charge current 8 mA plus 8 mA/step, clamped at code 56.
// RL10: Discharge limit 200 mA per step, code zero excluded, default 1001.
// RL11: Termination current 1 mA plus 2 mA/step, default 0001.
// RL12: Regulation voltage 3.6 V plus 15 mV/step, default 101000.
// RL13: Precharge threshold bit and recharge offset bit, both default high.
// RL14: Watchdog period 00 off, 40/80/160 s; 00 overrides discharge enable.
// RL15: Termination only when enabled; keep-current bit continues charging.
// RL16: Safety timer enable, limit select, half rate under power path.
// RL17: Battery switch disable turns switch off; shipping delay selectable.
// RL18: Five interrupt masks suppress pulses when set, default zero.
// RL19: Junction regulation threshold 60/80/100/120 C, default 120.
// RL20: System regulation 4.2 V plus 50 mV/step, default 0111.
// RL21: Read-only status: watchdog, charge state, power path, good, thermal.
// RL22: Read-only fault flags; thermistor hot and cold in low bits.
// RL23: Faults latch; thermistor live; latched clears on read once ended.
// RL24: Registers reached over I2C at 7-bit address 03h, bit 0 LSB.
// RL25: Host writes to read-only status and fault bits are ignored.
module ccrb_top (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // I2C pins
    input wire i_scl,
    input wire i_sda,
    output reg o_sda_oe,
    // Live status from charger
    input wire [1:0] i_charge_state,
    input wire i_power_path_active,
    input wire i_input_good,
    input wire i_thermal_reg,
    input wire i_discharging,
    // Fault conditions from charger
    input wire i_input_fault,
    input wire i_thermal_shutdown,
    input wire i_battery_ov,
    input wire i_safety_timer_fault,
    input wire i_ntc_hot,
    input wire i_ntc_cold,
    // Power recycle request from button logic
    input wire i_recycle_req,
    // Configuration outputs
    output reg [3:0] o_input_current_limit,
    output reg [1:0] o_button_deglitch_time,
    output reg o_bypass_on,
    output reg o_charge_enable,
    output reg [2:0] o_battery_undervoltage_threshold,
    output reg [5:0] o_fast_charge_current,
    output reg [3:0] o_discharge_current_limit,
    output reg [3:0] o_termination_current,
    output reg [5:0] o_battery_regulation_voltage,
    output reg o_precharge_threshold_high,
    output reg o_recharge_offset,
    output reg o_termination_enable,
    output reg o_post_termination_keep_current,
    output reg o_safety_timer_enable,
    output reg [1:0] o_safety_timer_limit,
    output reg o_safety_timer_half_rate,
    output reg o_battery_switch_on,
    output reg [1:0] o_shipping_entry_delay,
    output reg [4:0] o_irq_mask,
    output reg [1:0] o_junction_regulation_threshold,
    output reg [3:0] o_system_regulation_voltage,
    output reg o_recycle_active
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ADDR = 4'h2;
    localparam [3:0] ST_WRITE = 4'h4;
    localparam [3:0] ST_READ = 4'h8;
    parameter [31:0] SEC_CYC = `CCRB_SEC_CYC;

    // ======================================================
    // Pin synchronisers
    reg [1:0] scl_s_q;
    reg [1:0] sda_s_q;
    reg scl_q;
    reg sda_q;
    always @(posedge i_clk_sys) begin
        scl_s_q <= {scl_s_q[0], i_scl};
        sda_s_q <= {sda_s_q[0], i_sda};
        scl_q <= scl_s_q[1];
        sda_q <= sda_s_q[1];
    end
    wire scl_rise = scl_s_q[1] & ~scl_q;
    wire scl_fall = ~scl_s_q[1] & scl_q;
    wire i2c_start = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    wire i2c_stop = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

    // ======================================================
    // Register storage
    reg [7:0] r0_q, r1_q, r2_q, r3_q, r4_q, r5_q, r6_q, r7_q;
    reg [1:0] ship_q;
    reg [3:0] flt_q;
    reg wd_flag_q;
    reg [7:0] ptr_q;

    // Read-back mux; fault register shows latched and live thermistor
    reg [7:0] rd_data;
    always @* begin
        rd_data = 8'h00;
        if (ptr_q == `CCRB_OFS_R0) begin
            rd_data = r0_q;
        end else if (ptr_q == `CCRB_OFS_R1) begin
            rd_data = r1_q;
        end else if (ptr_q == `CCRB_OFS_R2) begin
            rd_data = {1'b0, 1'b0, r2_q[5:0]};
        end else if (ptr_q == `CCRB_OFS_R3) begin
            rd_data = r3_q;
        end else if (ptr_q == `CCRB_OFS_R4) begin
            rd_data = r4_q;
        end else if (ptr_q == `CCRB_OFS_R5) begin
            rd_data = r5_q;
        end else if (ptr_q == `CCRB_OFS_R6) begin
            rd_data = r6_q;
        end else if (ptr_q == `CCRB_OFS_R7) begin
            rd_data = r7_q;
        end else if (ptr_q == `CCRB_OFS_R8) begin
            rd_data = {wd_flag_q, 2'b00, i_charge_state, // RL21
                i_power_path_active, i_input_good, i_thermal_reg};
        end else if (ptr_q == `CCRB_OFS_R9) begin
            rd_data = {ship_q, flt_q, i_ntc_hot, i_ntc_cold}; // RL22 RL23
        end
    end

    // ======================================================
    // I2C target state machine
    reg [3:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg ack_q;
    reg first_q;
    reg wr_stb_q;
    reg rd_done_q;
    always @(posedge i_clk_sys) begin
        wr_stb_q <= 1'b0;
        rd_done_q <= 1'b0;
        if (!i_rst_b) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            first_q <= 1'b0;
            ptr_q <= 8'h00;
            o_sda_oe <= 1'b0;
        end else if (i2c_start) begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (i2c_stop) begin
            st_q <= ST_IDLE;
            o_sda_oe <= 1'b0;
        end else if (scl_rise && !ack_q) begin
            sh_q <= {sh_q[6:0], sda_q};
            bit_q <= bit_q + 4'h1;
        end else if (scl_fall) begin
            case (st_q)
                ST_ADDR: begin
                    if (ack_q) begin
                        ack_q <= 1'b0;
                        bit_q <= 4'h0;
                        o_sda_oe <= 1'b0;
                        st_q <= sh_q[0] ? ST_READ : ST_WRITE;
                        first_q <= 1'b1;
                        if (sh_q[0]) begin
                            sh_q <= rd_data;
                            o_sda_oe <= ~rd_data[7];
                        end
                    end else if (bit_q == 4'h8) begin
                        if (sh_q[7:1] == `CCRB_I2C_ADDR) begin // RL24
                            ack_q <= 1'b1;
                            o_sda_oe <= 1'b1;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (ack_q) begin
                        ack_q <= 1'b0;
                        bit_q <= 4'h0;
                        o_sda_oe <= 1'b0;
                    end else if (bit_q == 4'h8) begin
                        ack_q <= 1'b1;
                        o_sda_oe <= 1'b1;
                        if (first_q) begin
                            ptr_q <= sh_q;
                            first_q <= 1'b0;
                        end else begin
                            wr_stb_q <= 1'b1;
                        end
                    end
                end
                ST_READ: begin
                    if (ack_q) begin
                        ack_q <= 1'b0;
                        bit_q <= 4'h0;
                        if (sda_q) begin
                            st_q <= ST_IDLE;
                            o_sda_oe <= 1'b0;
                        end else begin
                            sh_q <= rd_data;
                            o_sda_oe <= ~rd_data[7];
                        end
                    end else if (bit_q == 4'h8) begin
                        ack_q <= 1'b1;
                        o_sda_oe <= 1'b0;
                        rd_done_q <= 1'b1;
                        ptr_q <= ptr_q + 8'h01;
                    end else begin
                        o_sda_oe <= ~sh_q[7]; // Rise moved next bit up
                    end
                end
                default: begin
                    o_sda_oe <= 1'b0;
                end
            endcase
        end else if (scl_rise && ack_q) begin
            bit_q <= bit_q;
        end
    end
    // Strobe, offset and value of the last written data byte
    wire wr_hit = wr_stb_q;
    wire [7:0] wr_ofs = ptr_q;
    wire [7:0] wd = sh_q;

    // ======================================================
    // Watchdog period and counter
    wire [1:0] wd_sel = r5_q[6:5];
    wire wd_run = (wd_sel != 2'b00) // RL14
        && (!i_discharging || r5_q[`CCRB_BIT_WD_DIS]);
    wire kick = wr_hit && (wr_ofs == `CCRB_OFS_R2) && wd[`CCRB_BIT_KICK];
    wire swrst = wr_hit && (wr_ofs == `CCRB_OFS_R2) && wd[`CCRB_BIT_SWRST];
    reg [31:0] div_q;
    reg sec_tick_q;
    reg [7:0] wd_cnt_q;
    reg wd_exp_q;
    wire [7:0] wd_lim = (wd_sel == 2'b01) ? 8'd40 :
        (wd_sel == 2'b10) ? 8'd80 : 8'd160;
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            div_q <= 32'h0;
            sec_tick_q <= 1'b0;
        end else begin
            sec_tick_q <= (div_q == SEC_CYC - 32'h1);
            div_q <= (div_q == SEC_CYC - 32'h1) ? 32'h0 : div_q + 32'h1;
        end
    end
    always @(posedge i_clk_sys) begin
        wd_exp_q <= 1'b0;
        if (!i_rst_b || kick || swrst || !wd_run) begin // RL8
            wd_cnt_q <= 8'h00;
        end else if (sec_tick_q) begin
            if (wd_cnt_q + 8'h01 >= wd_lim) begin
                wd_cnt_q <= 8'h00;
                wd_exp_q <= 1'b1;
            end else begin
                wd_cnt_q <= wd_cnt_q + 8'h01;
            end
        end
    end

    // ======================================================
    // Writable registers: software reset, watchdog subset, host write
    always @(posedge i_clk_sys) begin
        if (!i_rst_b || swrst) begin // RL7
            r0_q <= `CCRB_RST_R0;
            r1_q <= `CCRB_RST_R1; // RL1 RL2 RL6
            r2_q <= `CCRB_RST_R2;
            r3_q <= `CCRB_RST_R3;
            r4_q <= `CCRB_RST_R4;
            r5_q <= `CCRB_RST_R5;
            r6_q <= `CCRB_RST_R6;
            r7_q <= `CCRB_RST_R7;
            ship_q <= 2'b00;
        end else if (wd_exp_q) begin // RL7
            r1_q <= (r1_q & ~`CCRB_WDM_R1) | (`CCRB_RST_R1 & `CCRB_WDM_R1);
            r2_q <= (r2_q & ~`CCRB_WDM_R2) | (`CCRB_RST_R2 & `CCRB_WDM_R2);
            r3_q <= (r3_q & ~`CCRB_WDM_R3) | (`CCRB_RST_R3 & `CCRB_WDM_R3);
            r4_q <= (r4_q & ~`CCRB_WDM_R4) | (`CCRB_RST_R4 & `CCRB_WDM_R4);
            r5_q <= (r5_q & ~`CCRB_WDM_R5) | (`CCRB_RST_R5 & `CCRB_WDM_R5);
            r6_q <= (r6_q & ~`CCRB_WDM_R6) | (`CCRB_RST_R6 & `CCRB_WDM_R6);
            r7_q <= (r7_q & ~`CCRB_WDM_R7) | (`CCRB_RST_R7 & `CCRB_WDM_R7);
        end else if (wr_hit) begin
            if (wr_ofs == `CCRB_OFS_R0) begin
                r0_q <= wd;
            end else if (wr_ofs == `CCRB_OFS_R1) begin
                r1_q <= wd;
            end else if (wr_ofs == `CCRB_OFS_R2) begin
                r2_q <= {2'b00, wd[5:0]}; // Kick and reset self-clear
            end else if (wr_ofs == `CCRB_OFS_R3) begin
                r3_q <= wd;
            end else if (wr_ofs == `CCRB_OFS_R4) begin
                r4_q <= wd;
            end else if (wr_ofs == `CCRB_OFS_R5) begin
                r5_q <= wd;
            end else if (wr_ofs == `CCRB_OFS_R6) begin
                r6_q <= wd;
            end else if (wr_ofs == `CCRB_OFS_R7) begin
                r7_q <= wd;
            end else if (wr_ofs == `CCRB_OFS_R9) begin
                ship_q <= wd[7:6]; // RL25
            end
        end
    end

    // ======================================================
    // Fault latches: set wins over clear-on-read
    wire [3:0] flt_now = {i_input_fault, i_thermal_shutdown,
        i_battery_ov, i_safety_timer_fault};
    wire rd9 = rd_done_q && (ptr_q == `CCRB_OFS_R9 + 8'h01);
    wire rd8 = rd_done_q && (ptr_q == `CCRB_OFS_R8 + 8'h01);
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            flt_q <= 4'h0;
            wd_flag_q <= 1'b0;
        end else begin
            flt_q <= flt_now | (rd9 ? 4'h0 : flt_q); // RL23
            wd_flag_q <= wd_exp_q | (wd_flag_q & ~rd8);
        end
    end

    // ======================================================
    // Power recycle off-time, counted from the request in whole seconds
    reg [2:0] off_cnt_q;
    reg [31:0] off_div_q;
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            off_cnt_q <= 3'h0;
            off_div_q <= 32'h0;
            o_recycle_active <= 1'b0;
        end else if (i_recycle_req || wd_exp_q) begin
            off_cnt_q <= r1_q[`CCRB_BIT_OFFTIME] ? // RL3
                3'd`CCRB_OFF_LONG_S : 3'd`CCRB_OFF_SHORT_S;
            off_div_q <= 32'h0;
            o_recycle_active <= 1'b1;
        end else if (o_recycle_active) begin
            if (off_div_q == SEC_CYC - 32'h1) begin
                off_div_q <= 32'h0;
                off_cnt_q <= off_cnt_q - 3'h1;
                o_recycle_active <= (off_cnt_q != 3'h1);
            end else begin
                off_div_q <= off_div_q + 32'h1;
            end
        end
    end

    // ======================================================
    // Decoded configuration outputs
    always @(posedge i_clk_sys) begin
        o_input_current_limit <= r0_q[3:0]; // RL1
        o_button_deglitch_time <= r1_q[7:6]; // RL2
        o_bypass_on <= ~r1_q[`CCRB_BIT_BYPASS_OFF] // RL4
            & ~o_recycle_active;
        o_charge_enable <= ~r1_q[`CCRB_BIT_CHG_DIS_N]; // RL5
        o_battery_undervoltage_threshold <= r1_q[2:0]; // RL6
        o_fast_charge_current <= (r2_q[5:0] > `CCRB_ICC_MAX) ?
            `CCRB_ICC_MAX : r2_q[5:0]; // RL9
        o_discharge_current_limit <= (r3_q[7:4] == 4'h0) ?
            4'h1 : r3_q[7:4]; // RL10
        o_termination_current <= r3_q[3:0]; // RL11
        o_battery_regulation_voltage <= r4_q[7:2]; // RL12
        o_precharge_threshold_high <= r4_q[1]; // RL13
        o_recharge_offset <= r4_q[0]; // RL13
        o_termination_enable <= r5_q[`CCRB_BIT_TERM_EN]; // RL15
        o_post_termination_keep_current <= r5_q[`CCRB_BIT_KEEP_CUR]; // RL15
        o_safety_timer_enable <= r5_q[`CCRB_BIT_TMR_EN]; // RL16
        o_safety_timer_limit <= r5_q[2:1]; // RL16
        o_safety_timer_half_rate <= r6_q[`CCRB_BIT_HALF_RATE] // RL16
            & i_power_path_active;
        o_battery_switch_on <= ~r6_q[`CCRB_BIT_SW_DIS] // RL17
            & ~o_recycle_active;
        o_shipping_entry_delay <= ship_q; // RL17
        o_irq_mask <= r6_q[4:0]; // RL18
        o_junction_regulation_threshold <= r7_q[5:4]; // RL19
        o_system_regulation_voltage <= r7_q[3:0]; // RL20
    end
endmodule

/* File: tb/ccrb_chk.sv */
// Checker for the charger register bank top-level ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module ccrb_chk #(
    parameter [31:0] SEC_CYC = 32'd20
) (
    // Clock, reset and stimulus
    input wire i_clk_sys,
    input wire i_rst_b,
    input wire i_scl,
    input wire i_power_path_active,
    input wire i_recycle_req,
    // Observed outputs
    input wire o_sda_oe,
    input wire [3:0] o_input_current_limit,
    input wire o_charge_enable,
    input wire [5:0] o_fast_charge_current,
    input wire [3:0] o_discharge_current_limit,
    input wire o_bypass_on,
    input wire o_battery_switch_on,
    input wire o_safety_timer_half_rate,
    input wire o_recycle_active
);
    int unsigned rc_q;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    // ==========================================================
    // Length of the current recycle off period
    always @(posedge i_clk_sys) begin
        if (!i_rst_b || !o_recycle_active) begin
            rc_q <= 0;
        end else begin
            rc_q <= rc_q + 1;
        end
    end
    // ==========================================================
    // Assertions
    rst_dflt_a: assert property (
        $rose(i_rst_b) |-> o_input_current_limit == 4'hf && !o_charge_enable
        && o_fast_charge_current == 6'h0f && o_discharge_current_limit == 4'h9)
        else $error("decoded defaults wrong after reset");
    icc_clamp_a: assert property (
        o_fast_charge_current <= 6'h38)
        else $error("charge current above clamp");
    dsc_nonzero_a: assert property (
        o_discharge_current_limit != 4'h0)
        else $error("discharge limit shows code zero");
    rec_start_a: assert property (
        i_recycle_req |-> ##[1:3] o_recycle_active)
        else $error("recycle did not start");
    rec_off_a: assert property (
        o_recycle_active && $past(o_recycle_active) |->
        !o_bypass_on && !o_battery_switch_on)
        else $error("switch on during recycle");
    rec_len_a: assert property (
        $fell(o_recycle_active) |->
        rc_q inside {[2*SEC_CYC-1:2*SEC_CYC+1], [4*SEC_CYC-1:4*SEC_CYC+1]})
        else $error("recycle off time wrong");
    sda_phase_a: assert property (
        $changed(o_sda_oe) |-> !i_scl)
        else $error("data line moved while clock high");
    half_rate_a: assert property (
        !i_power_path_active [*3] |-> !o_safety_timer_half_rate)
        else $error("half rate without power path");
    // Main scenarios reached
    cover property ($rose(o_recycle_active));
    cover property ($rose(o_sda_oe));
    cover property ($rose(o_safety_timer_half_rate));
endmodule

/* File: tb/ccrb_host.sv */
// Host controller model for the two-wire register bus.
// Assumes an open-drain data line with pull-up, clocked by the bench.
`timescale 1ns/1ps
module ccrb_host (
    // Clock and device drive
    input wire i_clk_sys,
    input wire i_sda_dev_oe,
    // Bus lines
    output reg o_scl,
    output wire o_sda
);
    localparam int Q = 5;
    reg sda_oe_q = 1'b0;
    // Wired-AND data line, pulled up when nobody drives
    assign o_sda = ~(sda_oe_q | i_sda_dev_oe);
    initial o_scl = 1'b1;
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // One bit: data set while clock low, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_oe_q <= ~b;
        wt(Q);
        o_scl <= 1'b1;
        wt(Q);
        r = o_sda;
        wt(Q);
        o_scl <= 1'b0;
        wt(Q);
    endtask
    // Start or repeated start
    task automatic start;
        sda_oe_q <= 1'b0;
        wt(Q);
        o_scl <= 1'b1;
        wt(Q);
        sda_oe_q <= 1'b1;
        wt(Q);
        o_scl <= 1'b0;
        wt(Q);
    endtask
    task automatic stop;
        sda_oe_q <= 1'b1;
        wt(Q);
        o_scl <= 1'b1;
        wt(Q);
        sda_oe_q <= 1'b0;
        wt(2*Q);
    endtask
    // Byte MSB first plus acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic a_in,
                        output logic [7:0] q, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(a_in, a);
    endtask
    // Address, pointer, data; ok when all three acknowledged
    task automatic wr(input logic [6:0] ad, input logic [7:0] p,
                      input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        xfer({ad, 1'b0}, 1'b1, q, a0);
        xfer(p, 1'b1, q, a1);
        xfer(d, 1'b1, q, a2);
        stop();
        ok = !(a0 | a1 | a2);
    endtask
    // Pointer write, repeated start, one byte read with NACK
    task automatic rd(input logic [7:0] p, output logic [7:0] q);
        logic [7:0] x;
        logic a;
        start();
        xfer({7'h03, 1'b0}, 1'b1, x, a);
        xfer(p, 1'b1, x, a);
        start();
        xfer({7'h03, 1'b1}, 1'b1, x, a);
        xfer(8'hff, 1'b1, q, a);
        stop();
    endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the charger register bank.
// Assumes the host model drives the bus and status inputs are levels.
`timescale 1ns/1ps
`include "ccrb_defs.vh"
module tb;
    localparam int SEC = 40;
    reg i_clk_sys = 1'b0;
    reg i_rst_b = 1'b0;
    reg [1:0] st_q = 2'h0;
    reg pp_q = 1'b0, pg_q = 1'b0, th_q = 1'b0, ov_q = 1'b0;
    reg hot_q = 1'b0, rq_q = 1'b0, dis_q = 1'b0;
    wire scl, sda, sda_oe, byp, chg, sw, half, rec;
    wire [3:0] icl, dsc;
    wire [2:0] uv;
    wire [5:0] fast_charge_current;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    logic ok;
    logic [7:0] q;
    logic [7:0] dflt [0:9] = '{8'h9f, 8'hac, 8'h0f, 8'h91, 8'ha3,
                                8'h1a, 8'hc0, 8'h37, 8'h00, 8'h00};
    ccrb_host i_ccrb_host (.i_clk_sys(i_clk_sys), .i_sda_dev_oe(sda_oe),
        .o_scl(scl), .o_sda(sda));
    ccrb_top #(.SEC_CYC(SEC)) i_ccrb_top (.i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe),
        .i_charge_state(st_q), .i_power_path_active(pp_q),
        .i_input_good(pg_q), .i_thermal_reg(th_q), .i_discharging(dis_q),
        .i_input_fault(ov_q), .i_thermal_shutdown(1'b0),
        .i_battery_ov(ov_q), .i_safety_timer_fault(1'b0),
        .i_ntc_hot(hot_q), .i_ntc_cold(1'b0), .i_recycle_req(rq_q),
        .o_input_current_limit(icl), .o_button_deglitch_time(),
        .o_bypass_on(byp), .o_charge_enable(chg),
        .o_battery_undervoltage_threshold(uv), .o_fast_charge_current(fast_charge_current),
        .o_discharge_current_limit(dsc), .o_termination_current(),
        .o_battery_regulation_voltage(), .o_precharge_threshold_high(),
        .o_recharge_offset(), .o_termination_enable(),
        .o_post_termination_keep_current(), .o_safety_timer_enable(),
        .o_safety_timer_limit(), .o_safety_timer_half_rate(half),
        .o_battery_switch_on(sw), .o_shipping_entry_delay(), .o_irq_mask(),
        .o_junction_regulation_threshold(), .o_system_regulation_voltage(),
        .o_recycle_active(rec));
    // ==========================================================
    // Clock and hang guard
    initial forever #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [7:0] p, input logic [7:0] d);
        i_ccrb_host.wr(`CCRB_I2C_ADDR, p, d, ok);
        chk(ok, 1'b1);
    endtask
    task automatic r(input logic [7:0] p, input logic [7:0] e);
        i_ccrb_host.rd(p, q);
        chk(q, e);
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        chk(icl, 4'hf);
        chk(byp, 1'b1);
        w(8'h05, 8'h1a);
        for (int i = 0; i < 10; i++) r(i[7:0], dflt[i]);
        w(8'h01, 8'h10);
        chk(byp, 1'b0);
        chk(chg, 1'b1);
        chk(uv, 3'h0);
        w(8'h02, 8'h3f);
        chk(fast_charge_current, 6'h38);
        r(8'h02, 8'h3f);
        w(8'h03, 8'h0f);
        chk(dsc, 4'h1);
        w(8'h06, 8'he0);
        chk(sw, 1'b0);
        pp_q <= 1'b1;
        rq_q <= 1'b1;
        @(posedge i_clk_sys);
        rq_q <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        chk(half, 1'b1);
        chk(rec, 1'b1);
        repeat (2*SEC+4) @(posedge i_clk_sys);
        chk(rec, 1'b0);
        st_q <= 2'h2;
        pg_q <= 1'b1;
        th_q <= 1'b1;
        ov_q <= 1'b1;
        hot_q <= 1'b1;
        w(8'h08, 8'hff);
        w(8'h09, 8'hff);
        r(8'h08, 8'h17);
        ov_q <= 1'b0;
        r(8'h09, 8'hea);
        hot_q <= 1'b0;
        r(8'h09, 8'hc0);
        {st_q, pp_q, pg_q, th_q} <= 5'h0;
        i_ccrb_host.wr(7'h04, 8'h01, 8'h00, ok);
        chk(ok, 1'b0);
        r(8'h01, 8'h10);
        w(8'h02, 8'h80);
        r(8'h01, 8'hac);
        r(8'h02, 8'h0f);
        w(8'h01, 8'h00);
        w(8'h06, 8'h1f);
        w(8'h05, 8'h3a);
        repeat (3) w(8'h02, 8'h40);
        chk(rec, 1'b0);
        n = 0;
        while (rec !== 1'b1 && n < 2000) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk(n > 1500 && n < 1650, 1'b1);
        dis_q <= 1'b1; // Watchdog off in discharge unless enabled
        while (rec === 1'b1 && n < 4000) begin
            @(posedge i_clk_sys);
            n++;
        end
        r(8'h01, 8'hac);
        r(8'h06, 8'hc0);
        r(8'h05, 8'h3a);
        r(8'h08, 8'h80);
        repeat (1700) @(posedge i_clk_sys);
        r(8'h08, 8'h00);
        complete_run();
    end
endmodule
bind ccrb_top ccrb_chk #(.SEC_CYC(SEC_CYC)) i_ccrb_chk (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(i_scl),
    .i_power_path_active(i_power_path_active), .i_recycle_req(i_recycle_req),
    .o_sda_oe(o_sda_oe), .o_input_current_limit(o_input_current_limit),
    .o_charge_enable(o_charge_enable),
    .o_fast_charge_current(o_fast_charge_current),
    .o_discharge_current_limit(o_discharge_current_limit),
    .o_bypass_on(o_bypass_on), .o_battery_switch_on(o_battery_switch_on),
    .o_safety_timer_half_rate(o_safety_timer_half_rate),
    .o_recycle_active(o_recycle_active));
